/* rtl/sms_sequencer.sv */
// Start/stop sequencer: turns run, reverse, inch, stop-hold and permit inputs plus keypad
// keys into run, direction and power-stage decisions.
// Assumes all inputs are asynchronous switches or keys; the ramp logic reports standstill.
// How it works
// [RULE_01] Stop-hold low over 100 ms starts stopping
// [RULE_02] Started stop sequence always runs to standstill
// [RULE_03] Stop-hold inactive: run only while held
// [RULE_04] Permit false always disables the power stage
// [RULE_05] Single wire: forward-run held means run
// [RULE_06] Two wire: lone input picks direction
// [RULE_07] Both run inputs true: ignore, stop
// [RULE_08] Stop-hold true latches momentary run inputs
// [RULE_09] Stop-hold false: no latching, drive stops
// [RULE_10] Reverse pulse while forward switches to reverse
// [RULE_11] Inch never latched, only while held
// [RULE_12] Keys ignored in remote, pins in local
// [RULE_13] Local/remote key works in both modes
// [RULE_14] Toggle switches sequencing and reference together
// [RULE_15] Reset selects remote, local keys inactive
// [RULE_16] Run or inch exclusive; change via stopped
// [RULE_17] No-fault status true when not tripped
// [RULE_18] Stop-hold low time counted on mclk
// [RULE_19] All switch and key inputs synchronised first
`timescale 1ns/1ps
`include "sms_cfg.svh"

module sms_sequencer #(
  parameter int STOP_LOW_CYC = `SMS_STOP_LOW_MS * `SMS_MCLK_KHZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic stop_hold_input,
  input wire logic inch_request,
  input wire logic stage_permit,
  input wire logic trip_active,
  input wire logic motor_at_standstill,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic key_inch,
  input wire logic key_direction,
  input wire logic key_local_remote,
  output logic stage_enable,
  output logic run_active,
  output logic inch_active,
  output logic dir_reverse,
  output logic stopping,
  output logic running_status,
  output logic no_fault_status,
  output logic local_seq,
  output logic local_ref
);

  function automatic logic sms_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  localparam logic [`SMS_CNT_W-1:0] LOW_CYC = STOP_LOW_CYC[`SMS_CNT_W-1:0];
  localparam logic [`SMS_CNT_W-1:0] LOW_SAT = LOW_CYC + `SMS_CNT_W'(1);

  logic [`SMS_IN_W-1:0] pins;
  logic [`SMS_IN_W-1:0] lvl;
  logic [`SMS_IN_W-1:0] lvl_prev_r;
  logic [`SMS_CNT_W-1:0] low_cnt_r;
  logic low_qual;
  logic low_qual_prev_r;
  logic local_r;
  logic dir_r;
  sms_pkg::sms_state_t state_r;
  sms_pkg::sms_state_t state_nxt;
  logic dir_nxt;
  logic rem_fwd;
  logic rem_rev;
  logic rem_both;
  logic start_req;
  logic inch_req;
  logic stop_req;

  assign pins = {key_local_remote, key_direction, key_inch, key_stop, key_run, trip_active,
                 stage_permit, inch_request, stop_hold_input, reverse_run_input,
                 forward_run_input};

  sms_sync3 #(.W(`SMS_IN_W)) u_sync (  // RULE_19
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(pins),
    .level_out(lvl)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lvl_prev_r <= '0;
    end else begin
      lvl_prev_r <= lvl;
    end
  end

  // Starts saturated so an unwired stop-hold means no latching from reset on
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_cnt_r <= LOW_SAT;
    end else if (lvl[`SMS_B_HOLD]) begin
      low_cnt_r <= '0;  // RULE_18
    end else if (low_cnt_r != LOW_SAT) begin
      low_cnt_r <= low_cnt_r + `SMS_CNT_W'(1);  // RULE_18
    end
  end

  assign low_qual = (low_cnt_r > LOW_CYC);  // RULE_01

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_qual_prev_r <= 1'b1;
    end else begin
      low_qual_prev_r <= low_qual;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      local_r <= `SMS_RST_LOCAL;  // RULE_15
    end else if (sms_rise(lvl[`SMS_B_K_LR], lvl_prev_r[`SMS_B_K_LR])) begin
      local_r <= ~local_r;  // RULE_13 RULE_14
    end
  end

  assign rem_both = lvl[`SMS_B_FWD] & lvl[`SMS_B_REV];  // RULE_07
  assign rem_fwd = lvl[`SMS_B_FWD] & ~lvl[`SMS_B_REV];  // RULE_05 RULE_06
  assign rem_rev = lvl[`SMS_B_REV] & ~lvl[`SMS_B_FWD];  // RULE_06

  // Only the selected source reaches the sequencing logic
  always_comb begin
    if (local_r) begin  // RULE_12
      start_req = sms_rise(lvl[`SMS_B_K_RUN], lvl_prev_r[`SMS_B_K_RUN]);
      inch_req = lvl[`SMS_B_K_INCH];
      stop_req = sms_rise(lvl[`SMS_B_K_STOP], lvl_prev_r[`SMS_B_K_STOP]);
    end else begin
      start_req = rem_fwd | rem_rev;
      inch_req = lvl[`SMS_B_INCH];
      // Unlatched: stop as soon as no lone run input is held
      stop_req = rem_both | (low_qual & ~low_qual_prev_r)  // RULE_07 RULE_01 RULE_09
                 | (low_qual & ~(rem_fwd | rem_rev));  // RULE_03 RULE_05
    end
  end

  always_comb begin
    state_nxt = state_r;
    dir_nxt = dir_r;
    case (state_r)
      sms_pkg::SMS_STOPPED: begin
        // Inch takes precedence; run and inch never both start
        if (inch_req) begin
          state_nxt = sms_pkg::SMS_INCHING;  // RULE_16
        end else if (start_req) begin
          state_nxt = sms_pkg::SMS_RUNNING;
          if (!local_r) begin
            dir_nxt = rem_rev;  // RULE_06
          end
        end
      end
      sms_pkg::SMS_RUNNING: begin
        if (stop_req) begin
          state_nxt = sms_pkg::SMS_STOPPING;
        end else if (!local_r && rem_rev) begin
          dir_nxt = 1'b1;  // RULE_10
        end else if (!local_r && rem_fwd) begin
          dir_nxt = 1'b0;  // RULE_08
        end
      end
      sms_pkg::SMS_INCHING: begin
        if (!inch_req) begin
          state_nxt = sms_pkg::SMS_STOPPING;  // RULE_11
        end
      end
      sms_pkg::SMS_STOPPING: begin
        // Input changes cannot cancel a stop once started
        if (motor_at_standstill) begin
          state_nxt = sms_pkg::SMS_STOPPED;  // RULE_02
        end
      end
      default: begin
        state_nxt = sms_pkg::SMS_STOPPED;
      end
    endcase
    if (local_r && sms_rise(lvl[`SMS_B_K_DIR], lvl_prev_r[`SMS_B_K_DIR])) begin
      dir_nxt = ~dir_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= sms_pkg::SMS_STOPPED;
      dir_r <= `SMS_RST_DIR_REV;
    end else begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_enable <= 1'b0;
      run_active <= 1'b0;
      inch_active <= 1'b0;
      stopping <= 1'b0;
      running_status <= 1'b0;
      dir_reverse <= 1'b0;
      no_fault_status <= 1'b1;
      local_seq <= 1'b0;
      local_ref <= 1'b0;
    end else begin
      stage_enable <= lvl[`SMS_B_PERMIT] && (state_r != sms_pkg::SMS_STOPPED);  // RULE_04
      run_active <= (state_r == sms_pkg::SMS_RUNNING);
      inch_active <= (state_r == sms_pkg::SMS_INCHING);
      stopping <= (state_r == sms_pkg::SMS_STOPPING);
      running_status <= (state_r != sms_pkg::SMS_STOPPED);
      dir_reverse <= dir_r;
      no_fault_status <= ~lvl[`SMS_B_TRIP];  // RULE_17
      local_seq <= local_r;  // RULE_14
      local_ref <= local_r;
    end
  end

  chk_permit_gates_stage: assert property (  // RULE_04
    @(posedge mclk) disable iff (!rst_n) !lvl[`SMS_B_PERMIT] |=> !stage_enable)
    else $error("stage enabled without permit");

  chk_stop_completes: assert property (  // RULE_02
    @(posedge mclk) disable iff (!rst_n)
    (state_r == sms_pkg::SMS_STOPPING && !motor_at_standstill)
      |=> state_r == sms_pkg::SMS_STOPPING)
    else $error("stop sequence abandoned");

  chk_both_inputs_stop: assert property (  // RULE_07
    @(posedge mclk) disable iff (!rst_n)
    (!local_r && rem_both && state_r == sms_pkg::SMS_RUNNING)
      |=> state_r == sms_pkg::SMS_STOPPING)
    else $error("both run inputs did not stop");

  // The counter restarts from zero on each fall, so eight low cycles never qualify
  chk_low_time_qualify: assert property (  // RULE_18
    @(posedge mclk) disable iff (!rst_n)
    $fell(lvl[`SMS_B_HOLD]) ##0 !lvl[`SMS_B_HOLD] [*8] |-> !low_qual)
    else $error("short stop-hold pulse qualified");

  chk_qual_stops_run: assert property (  // RULE_01
    @(posedge mclk) disable iff (!rst_n)
    (!local_r && low_qual && !low_qual_prev_r && state_r == sms_pkg::SMS_RUNNING)
      |=> state_r == sms_pkg::SMS_STOPPING ##1 stopping)
    else $error("qualified stop-hold low did not stop");

  chk_inch_not_latched: assert property (  // RULE_11
    @(posedge mclk) disable iff (!rst_n)
    (state_r == sms_pkg::SMS_INCHING && !inch_req) |=> !(state_r == sms_pkg::SMS_INCHING)
      ##1 !inch_active)
    else $error("inch continued after release");

  chk_reverse_switch: assert property (  // RULE_10
    @(posedge mclk) disable iff (!rst_n)
    (!local_r && state_r == sms_pkg::SMS_RUNNING && !stop_req && rem_rev)
      |=> dir_r ##1 dir_reverse)
    else $error("reverse pulse did not reverse");

  chk_run_inch_exclusive: assert property (  // RULE_16
    @(posedge mclk) disable iff (!rst_n)
    (state_r == sms_pkg::SMS_RUNNING) |=> (state_r != sms_pkg::SMS_INCHING))
    else $error("changed from run to inch without stopping");

  chk_inch_run_exclusive: assert property (  // RULE_16
    @(posedge mclk) disable iff (!rst_n)
    (state_r == sms_pkg::SMS_INCHING) |=> (state_r != sms_pkg::SMS_RUNNING))
    else $error("changed from inch to run without stopping");

  chk_keys_ignored_remote: assert property (  // RULE_12
    @(posedge mclk) disable iff (!rst_n)
    (!local_r && state_r == sms_pkg::SMS_STOPPED && !inch_req && !rem_fwd && !rem_rev)
      |=> state_r == sms_pkg::SMS_STOPPED)
    else $error("remote mode started without remote input");

  chk_no_fault_follows: assert property (  // RULE_17
    @(posedge mclk) disable iff (!rst_n) lvl[`SMS_B_TRIP] |=> !no_fault_status)
    else $error("no-fault shown while tripped");

endmodule

/* include/sms_cfg.svh */
// Constants for the motor start/stop sequencer: timing, reset values and input bit positions.
// Assumes a single 40 MHz system clock.
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

`define SMS_MCLK_KHZ 40000
`define SMS_STOP_LOW_MS 100
`define SMS_CNT_W 23

// Positions in the synchronised input vector
`define SMS_IN_W 11
`define SMS_B_FWD 0
`define SMS_B_REV 1
`define SMS_B_HOLD 2
`define SMS_B_INCH 3
`define SMS_B_PERMIT 4
`define SMS_B_TRIP 5
`define SMS_B_K_RUN 6
`define SMS_B_K_STOP 7
`define SMS_B_K_INCH 8
`define SMS_B_K_DIR 9
`define SMS_B_K_LR 10

// Reset values
`define SMS_RST_LOCAL 1'b0
`define SMS_RST_DIR_REV 1'b0

`endif

/* include/sms_pkg.sv */
// Types shared by the motor start/stop sequencer.
// Assumes the constants of sms_cfg.svh are included by the design files.
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_STOPPED,
    SMS_RUNNING,
    SMS_INCHING,
    SMS_STOPPING
  } sms_state_t;

endpackage

/* rtl/sms_sync3.sv */
// Three-stage synchroniser for a group of pins.
// Assumes each bit is an independent slow level (switch or key) from outside the mclk domain.
`timescale 1ns/1ps

module sms_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only once the second and third stages agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

/* sim/sms_panel.sv */
// Field switches and operator keypad in front of the sequencer.
// Assumes the bench calls put and press from one process; levels change on mclk rises.
`timescale 1ns/1ps
`include "sms_cfg.svh"

module sms_panel (
  input wire logic mclk,
  output logic [`SMS_IN_W-1:0] pins
);
  // Stop-hold switch is normally closed and permit is wired true, so both idle high
  initial pins = 11'h014;

  task automatic put(input int b, input logic v);
    @(posedge mclk);
    pins[b] <= v;
  endtask

  // Run, stop, direction and local/remote keys are edge-detected, so every press ends in a released level
  task automatic press(input int b);
    put(b, 1'b1);
    repeat (10) @(posedge mclk);
    put(b, 1'b0);
    repeat (10) @(posedge mclk);
    // Return off the edge so outputs read right after are settled
    #1;
  endtask
endmodule

/* sim/sms_sequencer_tb.sv */
// Self-checking bench for the start/stop sequencer.
// Assumes sms_panel drives the pins; stop-hold qualifies once 21 cycles low here.
`timescale 1ns/1ps
`include "sms_cfg.svh"

module sms_sequencer_tb;
  logic mclk, rst_n, standstill;
  logic [`SMS_IN_W-1:0] pins;
  logic stage_enable, run_active, inch_active, dir_reverse, stopping;
  logic running_status, no_fault_status, local_seq, local_ref;
  int n_mismatch = 0;
  int compares = 0;

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %b got %b", nm, e, g); end end

  sms_panel panel (.mclk(mclk), .pins(pins));

  sms_sequencer #(.STOP_LOW_CYC(20)) dut (
    .mclk(mclk), .rst_n(rst_n),
    .forward_run_input(pins[`SMS_B_FWD]), .reverse_run_input(pins[`SMS_B_REV]),
    .stop_hold_input(pins[`SMS_B_HOLD]), .inch_request(pins[`SMS_B_INCH]),
    .stage_permit(pins[`SMS_B_PERMIT]), .trip_active(pins[`SMS_B_TRIP]),
    .motor_at_standstill(standstill),
    .key_run(pins[`SMS_B_K_RUN]), .key_stop(pins[`SMS_B_K_STOP]),
    .key_inch(pins[`SMS_B_K_INCH]), .key_direction(pins[`SMS_B_K_DIR]),
    .key_local_remote(pins[`SMS_B_K_LR]),
    .stage_enable(stage_enable), .run_active(run_active), .inch_active(inch_active),
    .dir_reverse(dir_reverse), .stopping(stopping), .running_status(running_status),
    .no_fault_status(no_fault_status), .local_seq(local_seq), .local_ref(local_ref)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic sw(input int b, input logic v);
    panel.put(b, v);
    cyc(10);
    #1;
  endtask

  // Expected {running_status, run_active, inch_active, stopping}
  task automatic look(input string w, input logic [3:0] e);
    #1;
    `CHK(w, e, {running_status, run_active, inch_active, stopping})
  endtask

  // Ramp logic reports rest for a few cycles
  task automatic halt();
    @(posedge mclk);
    standstill <= 1'b1;
    cyc(4);
    standstill <= 1'b0;
    cyc(4);
  endtask

  task automatic t_latch();
    sw(`SMS_B_FWD, 1'b1);
    look("fwd", 4'hc);
    `CHK("dir", 1'b0, dir_reverse)
    `CHK("stage", 1'b1, stage_enable)
    sw(`SMS_B_FWD, 1'b0);
    look("latched", 4'hc);
    sw(`SMS_B_PERMIT, 1'b0);
    `CHK("stage", 1'b0, stage_enable)
    sw(`SMS_B_PERMIT, 1'b1);
    sw(`SMS_B_REV, 1'b1);
    sw(`SMS_B_REV, 1'b0);
    look("rev", 4'hc);
    `CHK("dir", 1'b1, dir_reverse)
    panel.put(`SMS_B_HOLD, 1'b0);
    cyc(8);
    sw(`SMS_B_HOLD, 1'b1);
    look("short", 4'hc);
    panel.put(`SMS_B_HOLD, 1'b0);
    cyc(32);
    sw(`SMS_B_HOLD, 1'b1);
    look("stop", 4'h9);
    halt();
    look("rest", 4'h0);
  endtask

  task automatic t_wire();
    panel.put(`SMS_B_HOLD, 1'b0);
    cyc(32);
    sw(`SMS_B_FWD, 1'b1);
    look("fwd", 4'hc);
    `CHK("dir", 1'b0, dir_reverse)
    sw(`SMS_B_FWD, 1'b0);
    look("drop", 4'h9);
    halt();
    sw(`SMS_B_REV, 1'b1);
    look("rev", 4'hc);
    `CHK("dir", 1'b1, dir_reverse)
    sw(`SMS_B_FWD, 1'b1);
    look("both", 4'h9);
    halt();
    look("both", 4'h0);
    panel.put(`SMS_B_REV, 1'b0);
    sw(`SMS_B_FWD, 1'b0);
    halt();
  endtask

  task automatic t_inch();
    sw(`SMS_B_INCH, 1'b1);
    look("inch", 4'ha);
    sw(`SMS_B_FWD, 1'b1);
    look("excl", 4'ha);
    sw(`SMS_B_INCH, 1'b0);
    look("unheld", 4'h9);
    sw(`SMS_B_FWD, 1'b0);
    halt();
    look("rest", 4'h0);
  endtask

  task automatic t_local();
    panel.press(`SMS_B_K_LR);
    `CHK("local", 2'b11, {local_seq, local_ref})
    sw(`SMS_B_FWD, 1'b1);
    look("pin", 4'h0);
    sw(`SMS_B_FWD, 1'b0);
    panel.press(`SMS_B_K_RUN);
    look("krun", 4'hc);
    `CHK("kdir", 1'b0, dir_reverse)
    panel.press(`SMS_B_K_DIR);
    `CHK("kdir", 1'b1, dir_reverse)
    panel.press(`SMS_B_K_STOP);
    look("kstop", 4'h9);
    halt();
    sw(`SMS_B_K_INCH, 1'b1);
    look("kinch", 4'ha);
    sw(`SMS_B_K_INCH, 1'b0);
    look("kinch", 4'h9);
    halt();
    panel.press(`SMS_B_K_LR);
    `CHK("remote", 2'b00, {local_seq, local_ref})
    panel.press(`SMS_B_K_RUN);
    look("key", 4'h0);
    sw(`SMS_B_TRIP, 1'b1);
    `CHK("no_fault_status", 1'b0, no_fault_status)
    sw(`SMS_B_TRIP, 1'b0);
    `CHK("no_fault_status", 1'b1, no_fault_status)
  endtask

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Scenarios need about 530 cycles; allow a wide margin
  initial begin
    cyc(6000);
    n_mismatch++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    standstill = 1'b0;
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
    look("reset", 4'h0);
    `CHK("no_fault_status", 1'b1, no_fault_status)
    `CHK("local", 2'b00, {local_seq, local_ref})
    t_latch();
    t_wire();
    t_inch();
    t_local();
    results();
  end
endmodule
